// [dcre_dma_engine.sv]
/*
 * Eight-channel transfer engine with register port, request selection,
 * manual forcing, addressing and block modes, and block interrupts.
 * Assumes request lines, RAM and peripheral ports are on sys_clk, and
 * that both read ports return data the cycle after their read strobe.
 */
`timescale 1ns/1ps
module dcre_dma_engine
  import dcre_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [RAW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [DW-1:0] reg_rdata,
  input wire logic [NLINES-1:0] peripheral_transfer_request_line,
  input wire logic [AW-1:0] periph_ind_addr,
  output logic [AW-2:0] ram_addr,
  output logic [1:0] ram_be,
  output logic ram_we,
  output logic ram_re,
  output logic [DW-1:0] ram_wdata,
  input wire logic [DW-1:0] ram_rdata,
  output logic [PAW-1:0] periph_addr,
  output logic periph_we,
  output logic periph_re,
  output logic [DW-1:0] periph_wdata,
  input wire logic [DW-1:0] periph_rdata,
  output logic irq
);

  // ************************************************************
  // Declarations.
  // ************************************************************
  logic [DW-1:0] ctrl_reg [NCH];          // Channel control.
  logic [SELW-1:0] line_sel_reg [NCH];    // request_line_select field.
  logic force_reg [NCH];                  // Manual trigger flag.
  logic [AW-1:0] start_a_reg [NCH];       // First buffer start.
  logic [AW-1:0] start_b_reg [NCH];       // Second buffer start.
  logic [PAW-1:0] paddr_reg [NCH];        // Peripheral register address.
  logic [CNTW-1:0] count_reg [NCH];       // Block length less one.
  logic [AW-1:0] cur_addr_reg [NCH];      // Held RAM address.
  logic [CNTW-1:0] done_reg [NCH];        // Transfers done in this block.
  logic pp_sel_reg [NCH];                 // Second buffer in use.
  logic pend_reg [NCH];                   // Latched channel_trigger_request.
  logic line_prev_reg [NCH];              // Selected line, one cycle back.
  logic [NCH-1:0] int_status_reg;         // Sticky channel events.
  logic [NCH-1:0] int_enable_reg;         // Interrupt enables.
  logic [NCH-1:0] ready;                  // Channels asking for service.
  logic [NCH-1:0] event_pulse;            // Block or half-block events.
  logic [AW-1:0] eff_addr [NCH];          // RAM address for the next move.
  dcre_state_t state_reg;                 // Engine state.
  logic [CHW-1:0] svc_reg;                // Channel being served.
  logic [AW-1:0] xfer_addr_reg;           // RAM byte address of this move.
  logic [CHW-1:0] pick;                   // Arbitration winner.
  logic grant;                            // Engine takes a channel now.
  logic step;                             // A move finishes now.
  logic [DW-1:0] src_data;                // Data fetched from the source.
  logic chan_hit;                         // Register access hits a channel.
  logic glob_hit;                         // Register access hits globals.
  logic [CHW-1:0] acc_ch;                 // Channel addressed by software.
  logic [2:0] acc_sel;                    // Register within the block.

  assign acc_ch = reg_addr[7:5];
  assign acc_sel = reg_addr[4:2];
  assign chan_hit = !reg_addr[8];
  assign glob_hit = reg_addr[8];

  // ************************************************************
  // Per-channel logic.
  // ************************************************************
  // Every channel is the same hardware with its own register set.
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      logic wr_here;            // Software writes this channel block.
      logic my_step;            // Engine completes a move for us.
      logic is_last;            // This move ends the block.
      logic half_hit;           // This move reaches half block.
      logic [AW-1:0] next_base; // Start of the following block.
      logic stop_now;           // One-shot ends the channel here.
      logic [CNTW:0] half_pt;   // Moves that make up half a block.
      logic sel_line;           // The chosen request line.

      assign wr_here = reg_write && chan_hit && (acc_ch == CHW'(c));
      assign my_step = step && (svc_reg == CHW'(c));
      assign is_last = (done_reg[c] == count_reg[c]);
      assign half_pt = (CNTW+1)'((count_reg[c] + 11'h001) >> 1);
      assign half_hit = ({1'b0, done_reg[c]} + 11'h001) == half_pt;
      // Alternating modes swap buffers; others return to the first.
      assign next_base = (ctrl_reg[c][CTRL_BMODE_LO+1] && !pp_sel_reg[c]) ?
                         start_b_reg[c] : start_a_reg[c];
      // One-shot stops at block end; alternating one-shot after both.
      assign stop_now = (ctrl_reg[c][CTRL_BMODE_LO+1:CTRL_BMODE_LO] == BMODE_ONESHOT) ||
                        ((ctrl_reg[c][CTRL_BMODE_LO+1:CTRL_BMODE_LO] == BMODE_PP_ONE) &&
                         pp_sel_reg[c]);
      // Any of the 128 lines can trigger; twenty are wired to sources.
      assign sel_line = peripheral_transfer_request_line[line_sel_reg[c]];
      // Peripheral indirect ORs the peripheral's bits into the start.
      assign eff_addr[c] =
        (ctrl_reg[c][CTRL_AMODE_LO+1:CTRL_AMODE_LO] == AMODE_PERIPH) ?
        ((pp_sel_reg[c] ? start_b_reg[c] : start_a_reg[c]) | periph_ind_addr) :
        cur_addr_reg[c];
      // Forced channels run regardless of the line.
      assign ready[c] = ctrl_reg[c][CTRL_EN] && (force_reg[c] || pend_reg[c]);
      // Half-block replaces the full-block event when selected.
      assign event_pulse[c] = my_step &&
                              (ctrl_reg[c][CTRL_HALF] ? half_hit : is_last);

      // Control register; one-shot completion drops the enable.
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          ctrl_reg[c] <= 16'h0000;
        end else if (wr_here && acc_sel == REG_CTRL) begin
          ctrl_reg[c] <= reg_wdata & CTRL_MASK;
        end else if (my_step && is_last && stop_now) begin
          ctrl_reg[c][CTRL_EN] <= 1'b0;
        end
      end

      // Plain configuration registers.
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          line_sel_reg[c] <= 7'h00;
          start_a_reg[c] <= 11'h000;
          start_b_reg[c] <= 11'h000;
          paddr_reg[c] <= 10'h000;
          count_reg[c] <= 10'h000;
        end else if (wr_here) begin
          unique case (acc_sel)
            REG_REQ_SEL: line_sel_reg[c] <= reg_wdata[SELW-1:0];
            REG_START_A: start_a_reg[c] <= reg_wdata[AW-1:0];
            REG_START_B: start_b_reg[c] <= reg_wdata[AW-1:0];
            REG_PERIPH: paddr_reg[c] <= reg_wdata[PAW-1:0];
            REG_COUNT: count_reg[c] <= reg_wdata[CNTW-1:0];
            default: ;
          endcase
        end
      end

      // Force: writing one sets it, writing zero does nothing, and the
      // end of the forced move clears it. A set in the same cycle wins.
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          force_reg[c] <= 1'b0;
        end else if (wr_here && acc_sel == REG_REQ_SEL && reg_wdata[REQ_FORCE]) begin
          force_reg[c] <= 1'b1;
        end else if (my_step) begin
          force_reg[c] <= 1'b0;
        end
      end

      // Rising edge on the chosen line latches a trigger while in
      // automatic mode; a new edge beats the grant that clears it.
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          line_prev_reg[c] <= 1'b0;
          pend_reg[c] <= 1'b0;
        end else begin
          line_prev_reg[c] <= sel_line;
          if (sel_line && !line_prev_reg[c] && !force_reg[c] &&
              ctrl_reg[c][CTRL_EN]) begin
            pend_reg[c] <= 1'b1;
          end else if (grant && pick == CHW'(c)) begin
            pend_reg[c] <= 1'b0;
          end
        end
      end

      // Address, block progress and buffer selection.
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          cur_addr_reg[c] <= 11'h000;
          done_reg[c] <= 10'h000;
          pp_sel_reg[c] <= 1'b0;
        end else if (wr_here && acc_sel == REG_CTRL && reg_wdata[CTRL_EN] &&
                     !ctrl_reg[c][CTRL_EN]) begin
          // Enabling a channel starts a fresh block in the first buffer.
          cur_addr_reg[c] <= start_a_reg[c];
          done_reg[c] <= 10'h000;
          pp_sel_reg[c] <= 1'b0;
        end else if (my_step) begin
          if (is_last) begin
            cur_addr_reg[c] <= next_base;
            done_reg[c] <= 10'h000;
            pp_sel_reg[c] <= ctrl_reg[c][CTRL_BMODE_LO+1] && !pp_sel_reg[c];
          end else begin
            done_reg[c] <= done_reg[c] + 10'h001;
            if (ctrl_reg[c][CTRL_AMODE_LO+1:CTRL_AMODE_LO] == AMODE_INC) begin
              // Bytes advance by one, words by two.
              cur_addr_reg[c] <= cur_addr_reg[c] +
                                 (ctrl_reg[c][CTRL_BYTE] ? 11'h001 : 11'h002);
            end
          end
        end
      end

      // Sticky event bit; a new event beats a clear in the same cycle.
      always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
          int_status_reg[c] <= 1'b0;
        end else if (event_pulse[c]) begin
          int_status_reg[c] <= 1'b1;
        end else if (reg_write && glob_hit && acc_sel == REG_INT_CLEAR &&
                     reg_wdata[c]) begin
          int_status_reg[c] <= 1'b0;
        end
      end
    end
  endgenerate

  // ************************************************************
  // Arbitration.
  // ************************************************************
  // Lowest channel number wins; a busy engine grants nothing.
  always_comb begin
    pick = '0;
    for (int i = NCH - 1; i >= 0; i--) begin
      if (ready[i]) begin
        pick = CHW'(i);
      end
    end
  end

  assign grant = (state_reg == ST_IDLE) && (|ready);
  assign step = (state_reg == ST_WRITE);
  // Source data arrives the cycle after the read strobe.
  assign src_data = ctrl_reg[svc_reg][CTRL_TO_PERIPH] ? ram_rdata : periph_rdata;

  // ************************************************************
  // Transfer engine.
  // ************************************************************
  // The engine owns separate RAM and peripheral ports, so no processor
  // bus cycle is ever taken. One move costs four cycles.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
      svc_reg <= '0;
      xfer_addr_reg <= 11'h000;
      ram_addr <= '0;
      ram_be <= 2'h0;
      ram_we <= 1'b0;
      ram_re <= 1'b0;
      ram_wdata <= 16'h0000;
      periph_addr <= 10'h000;
      periph_we <= 1'b0;
      periph_re <= 1'b0;
      periph_wdata <= 16'h0000;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (grant) begin
            svc_reg <= pick;
            xfer_addr_reg <= eff_addr[pick];
            state_reg <= ST_READ;
            if (ctrl_reg[pick][CTRL_TO_PERIPH]) begin
              // RAM is the source.
              ram_re <= 1'b1;
              ram_addr <= eff_addr[pick][AW-1:1];
              ram_be <= 2'h3;
            end else begin
              periph_re <= 1'b1;
              periph_addr <= paddr_reg[pick];
            end
          end
        end
        ST_READ: begin
          ram_re <= 1'b0;
          periph_re <= 1'b0;
          state_reg <= ST_DATA;
        end
        ST_DATA: begin
          state_reg <= ST_WRITE;
          if (ctrl_reg[svc_reg][CTRL_TO_PERIPH]) begin
            periph_we <= 1'b1;
            periph_addr <= paddr_reg[svc_reg];
            if (ctrl_reg[svc_reg][CTRL_BYTE]) begin
              // Byte from the addressed lane, zero above.
              periph_wdata <= xfer_addr_reg[0] ? {8'h00, src_data[15:8]} :
                                                 {8'h00, src_data[7:0]};
            end else begin
              periph_wdata <= src_data;
            end
          end else begin
            ram_we <= 1'b1;
            ram_addr <= xfer_addr_reg[AW-1:1];
            if (ctrl_reg[svc_reg][CTRL_BYTE]) begin
              // Low byte copied to both lanes, one lane enabled.
              ram_wdata <= {src_data[7:0], src_data[7:0]};
              ram_be <= xfer_addr_reg[0] ? 2'h2 : 2'h1;
            end else begin
              ram_wdata <= src_data;
              ram_be <= 2'h3;
            end
          end
        end
        ST_WRITE: begin
          ram_we <= 1'b0;
          periph_we <= 1'b0;
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // ************************************************************
  // Interrupt enable and output.
  // ************************************************************
  // Enable register; the output lags status by one cycle so it can
  // leave a flip-flop directly.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      int_enable_reg <= 8'h00;
    end else if (reg_write && glob_hit && acc_sel == REG_INT_ENABLE) begin
      int_enable_reg <= reg_wdata[NCH-1:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(int_status_reg & int_enable_reg);
    end
  end

  // ************************************************************
  // Register read port.
  // ************************************************************
  // Data stands for exactly the cycle after the strobe; unmapped or
  // write-only addresses read zero.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (!reg_read) begin
      reg_rdata <= 16'h0000;
    end else if (chan_hit) begin
      unique case (acc_sel)
        REG_CTRL: reg_rdata <= ctrl_reg[acc_ch];
        // Bits 14..7 are unimplemented and read zero.
        REG_REQ_SEL: reg_rdata <= {force_reg[acc_ch], 8'h00, line_sel_reg[acc_ch]};
        REG_START_A: reg_rdata <= {5'h00, start_a_reg[acc_ch]};
        REG_START_B: reg_rdata <= {5'h00, start_b_reg[acc_ch]};
        REG_PERIPH: reg_rdata <= {6'h00, paddr_reg[acc_ch]};
        REG_COUNT: reg_rdata <= {6'h00, count_reg[acc_ch]};
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      unique case (acc_sel)
        REG_INT_STATUS: reg_rdata <= {8'h00, int_status_reg};
        REG_INT_ENABLE: reg_rdata <= {8'h00, int_enable_reg};
        REG_CHAN_STATE: reg_rdata <= {4'h0, state_reg != ST_IDLE, svc_reg,
                                      pp_sel_reg[7], pp_sel_reg[6], pp_sel_reg[5],
                                      pp_sel_reg[4], pp_sel_reg[3], pp_sel_reg[2],
                                      pp_sel_reg[1], pp_sel_reg[0]};
        default: reg_rdata <= 16'h0000;
      endcase
    end
  end

endmodule

// [dcre_pkg.sv]
/*
 * Constants shared by the eight-channel transfer engine: register map,
 * control field positions, mode encodings and fixed request numbers.
 * Assumes a 16-bit register port with byte addresses and a word-wide
 * dual-port transfer RAM with byte lane enables.
 */
package dcre_pkg;

  // ************************************************************
  // Sizes.
  // ************************************************************
  localparam int NCH = 8;            // Number of identical channels.
  localparam int CHW = 3;            // Width of a channel index.
  localparam int NLINES = 128;       // Peripheral request lines.
  localparam int SELW = 7;           // Width of the line select field.
  localparam int DW = 16;            // Register and data width.
  localparam int AW = 11;            // Transfer RAM byte address width.
  localparam int PAW = 10;           // Peripheral register address width.
  localparam int CNTW = 10;          // Block length field width.
  localparam int RAW = 9;            // Register port byte address width.

  // ************************************************************
  // Register map: per channel block of 32 bytes, then globals.
  // ************************************************************
  localparam logic [2:0] REG_CTRL = 3'h0;       // Channel control.
  localparam logic [2:0] REG_REQ_SEL = 3'h1;    // Channel request select.
  localparam logic [2:0] REG_START_A = 3'h2;    // First buffer start.
  localparam logic [2:0] REG_START_B = 3'h3;    // Second buffer start.
  localparam logic [2:0] REG_PERIPH = 3'h4;     // Peripheral address.
  localparam logic [2:0] REG_COUNT = 3'h5;      // Transfers per block less one.
  localparam logic [2:0] REG_INT_STATUS = 3'h0; // Global: sticky events.
  localparam logic [2:0] REG_INT_CLEAR = 3'h1;  // Global: write one to clear.
  localparam logic [2:0] REG_INT_ENABLE = 3'h2; // Global: interrupt enables.
  localparam logic [2:0] REG_CHAN_STATE = 3'h3; // Global: live channel state.

  // ************************************************************
  // Control register fields.
  // ************************************************************
  localparam int CTRL_EN = 15;       // Channel enable.
  localparam int CTRL_BYTE = 14;     // One byte per transfer when set.
  localparam int CTRL_TO_PERIPH = 13;// RAM to peripheral when set.
  localparam int CTRL_HALF = 12;     // Interrupt at half block.
  localparam int CTRL_AMODE_LO = 4;  // Addressing mode, two bits.
  localparam int CTRL_BMODE_LO = 0;  // Block mode, two bits.
  localparam logic [DW-1:0] CTRL_MASK = 16'hf033;
  localparam int REQ_FORCE = 15;     // Manual transfer trigger.

  // Addressing modes.
  localparam logic [1:0] AMODE_INC = 2'h0;    // Post-increment.
  localparam logic [1:0] AMODE_FIXED = 2'h1;  // Held address.
  localparam logic [1:0] AMODE_PERIPH = 2'h2; // Peripheral indirect.

  // Block modes.
  localparam logic [1:0] BMODE_CONT = 2'h0;     // Continuous.
  localparam logic [1:0] BMODE_ONESHOT = 2'h1;  // One block then stop.
  localparam logic [1:0] BMODE_PP_CONT = 2'h2;  // Alternating, continuous.
  localparam logic [1:0] BMODE_PP_ONE = 2'h3;   // Alternating, both then stop.

  // Fixed peripheral request numbers (examples of the line mapping).
  localparam logic [SELW-1:0] RQ_UART1_RX = 7'h0b;
  localparam logic [SELW-1:0] RQ_UART1_TX = 7'h0c;
  localparam logic [SELW-1:0] RQ_ADC1 = 7'h0d;
  localparam int NUM_SOURCES = 20;   // Peripherals that can raise lines.

  // Transfer engine states, one-hot.
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_READ = 4'h2,
    ST_DATA = 4'h4,
    ST_WRITE = 4'h8
  } dcre_state_t;

endpackage

// [dcre_dma_engine_props.sv]
/* Port checker for the eight-channel transfer engine.
   Assumes one clock domain and sees only the top module's ports. */
`timescale 1ns/1ps
module dcre_dma_engine_props
  import dcre_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [RAW-1:0] reg_addr,
  input wire logic reg_read,
  input wire logic [DW-1:0] reg_rdata,
  input wire logic ram_we,
  input wire logic ram_re,
  input wire logic [1:0] ram_be,
  input wire logic periph_we,
  input wire logic periph_re,
  input wire logic irq
);
  // Every check runs on the one clock and sleeps through reset.
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Reads of the request select never show the unused middle bits.
  a_sel_gap_zero: assert property (reg_read && !reg_addr[8] && reg_addr[4:2] == REG_REQ_SEL
    |=> reg_rdata[14:7] == 8'h00) else $error("request select gap bits not zero");
  a_rdata_idle_zero: assert property (!$past(reg_read) |-> reg_rdata == 16'h0000)
    else $error("read data outside its cycle");
  // Inbound moves read the peripheral two cycles before the RAM write.
  a_in_to_ram: assert property (periph_re |-> ##2 ram_we)
    else $error("peripheral read not followed by RAM write");
  a_ram_to_out: assert property (ram_re |-> ##2 periph_we)
    else $error("RAM read not followed by peripheral write");
  a_ram_we_cause: assert property (ram_we |-> $past(periph_re, 2))
    else $error("RAM write without peripheral read");
  a_out_we_cause: assert property (periph_we |-> $past(ram_re, 2))
    else $error("peripheral write without RAM read");
  // The engine's own bus carries one move at a time.
  a_one_source: assert property (!(ram_re && periph_re))
    else $error("both read strobes at once");
  a_lane_valid: assert property (ram_we |-> ram_be != 2'b00)
    else $error("RAM write with no byte lane");
  a_move_gap: assert property ((ram_re || periph_re) |=> !(ram_re || periph_re) [*3])
    else $error("moves closer than four cycles");
  c_byte_write: cover property (ram_we && ram_be != 2'b11);
  c_out_write: cover property (periph_we);
  c_irq_rise: cover property ($rose(irq));
endmodule
bind dcre_dma_engine dcre_dma_engine_props u_props (.sys_clk, .rst, .reg_addr, .reg_read,
  .reg_rdata, .ram_we, .ram_re, .ram_be, .periph_we, .periph_re, .irq);

// [dcre_far_side_model.sv]
/* Model of the transfer RAM and the peripheral registers.
   Assumes read data is wanted only in the cycle after a read strobe. */
`timescale 1ns/1ps
module dcre_far_side_model
  import dcre_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [AW-2:0] ram_addr,
  input wire logic [1:0] ram_be,
  input wire logic ram_we,
  input wire logic ram_re,
  input wire logic [DW-1:0] ram_wdata,
  output logic [DW-1:0] ram_rdata,
  input wire logic [PAW-1:0] periph_addr,
  input wire logic periph_re,
  output logic [DW-1:0] periph_rdata
);
  logic [DW-1:0] mem_reg [0:1023]; // Every buffer lives here.
  // Words start as a known pattern so the bench can predict them.
  initial begin
    ram_rdata = 16'h0000;
    periph_rdata = 16'h0000;
    for (int i = 0; i < 1024; i++) mem_reg[i] = {6'h2c, i[9:0]};
  end
  // Outside the answer cycle the data lines toggle, so stale data never matches.
  always @(posedge sys_clk) begin
    ram_rdata <= ram_re ? mem_reg[ram_addr] : ~ram_rdata;
    periph_rdata <= periph_re ? {6'h15, periph_addr} : ~periph_rdata;
    if (ram_we && ram_be[0]) mem_reg[ram_addr][7:0] <= ram_wdata[7:0];
    if (ram_we && ram_be[1]) mem_reg[ram_addr][15:8] <= ram_wdata[15:8];
  end
endmodule

// [dcre_dma_engine_tb_top.sv]
/* Self-checking bench for the transfer engine.
   Assumes the far side model and the bound port checker. */
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("ERROR t=%0t got %h exp %h", $time, a, e); end end
module dcre_dma_engine_tb_top;
  import dcre_pkg::*;
  logic sys_clk = 0, rst = 1, reg_write = 0, reg_read = 0, rd_q = 0;
  logic ram_we, ram_re, periph_we, periph_re, irq;
  logic [RAW-1:0] reg_addr = '0;
  logic [DW-1:0] reg_wdata = '0, reg_rdata, ram_wdata, ram_rdata, periph_wdata, periph_rdata;
  logic [NLINES-1:0] lines = '0;
  logic [AW-1:0] ind = '0, sa;
  logic [AW-2:0] ram_addr;
  logic [1:0] ram_be;
  logic [PAW-1:0] periph_addr;
  logic [15:0] pa, v;
  logic [31:0] exp_q[$];
  int err_count = 0, samples_checked = 0, cyc = 0;
  dcre_dma_engine u_dut (.sys_clk, .rst, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .peripheral_transfer_request_line(lines), .periph_ind_addr(ind), .ram_addr,
    .ram_be, .ram_we, .ram_re, .ram_wdata, .ram_rdata, .periph_addr, .periph_we, .periph_re,
    .periph_wdata, .periph_rdata, .irq);
  dcre_far_side_model u_far (.sys_clk, .ram_addr, .ram_be, .ram_we, .ram_re, .ram_wdata,
    .ram_rdata, .periph_addr, .periph_re, .periph_rdata);
  initial forever #25 sys_clk = ~sys_clk;
  function automatic logic [31:0] pk(input logic [1:0] k, input logic [1:0] b,
      input logic [9:0] a, input logic [15:0] d);
    return {2'b00, k, b, a, d};
  endfunction
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // A hung run is cut short and counted as a mismatch.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      print_verdict();
    end
  end
  // Results are matched in order against the oldest note; surplus results fail.
  task automatic got(input logic [31:0] x);
    logic [31:0] e;
    e = (exp_q.size() == 0) ? ~x : exp_q.pop_front();
    `CHK(x, e)
  endtask
  always @(posedge sys_clk) rd_q <= reg_read;
  always @(negedge sys_clk) begin
    if (rd_q) got(pk(1, 2'b00, 10'h000, reg_rdata));
    if (ram_we) got(pk(2, ram_be, ram_addr, ram_wdata));
    if (periph_we) got(pk(3, 2'b00, periph_addr, periph_wdata));
  end
  // Bus cycles leave one idle cycle so no strobe is assigned twice in a step.
  task automatic wr(input int a, input logic [15:0] d);
    reg_addr <= a[8:0];
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge sys_clk);
    reg_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic rd(input int a, input logic [15:0] e);
    exp_q.push_back(pk(1, 2'b00, 10'h000, e));
    reg_addr <= a[8:0];
    reg_read <= 1'b1;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(posedge sys_clk);
  endtask
  // One request edge, then time for the whole move and the interrupt lag.
  task automatic pulse(input int n);
    lines[n] <= 1'b1;
    @(posedge sys_clk);
    lines[n] <= 1'b0;
    repeat (7) @(posedge sys_clk);
  endtask
  task automatic ck_irq(input logic e);
    @(negedge sys_clk);
    `CHK(irq, e)
    @(posedge sys_clk);
  endtask
  initial begin
    v = 16'($urandom(32'h7784eaa6));
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    pa = 16'($urandom_range(1023));
    wr(32'h08, 16'h0040);
    wr(32'h14, 16'h0001);
    wr(32'h10, pa);
    wr(32'h04, {9'h000, RQ_UART1_RX});
    wr(32'h108, 16'h0001);
    wr(32'h00, 16'h8000);
    for (int i = 0; i < 3; i++) begin
      exp_q.push_back(pk(2, 2'b11, 10'h020 + 10'(i % 2), {6'h15, pa[9:0]}));
      pulse(RQ_UART1_RX);
      ck_irq(i > 0);
    end
    rd(32'h100, 16'h0001);
    wr(32'h104, 16'h0001);
    wr(32'h00, 16'h0000);
    ck_irq(1'b0);
    $display("continuous inbound test done");
    wr(32'h28, 16'h0081);
    wr(32'h34, 16'h0000);
    wr(32'h30, pa);
    wr(32'h20, 16'he011);
    exp_q.push_back(pk(3, 2'b00, pa[9:0], 16'h00b0));
    wr(32'h24, 16'h807f);
    wr(32'h24, 16'h007f);
    rd(32'h24, 16'h807f);
    repeat (8) @(posedge sys_clk);
    rd(32'h24, 16'h007f);
    rd(32'h20, 16'h6011);
    $display("forced byte test done");
    sa = 11'($urandom) & 11'h0fe;
    ind <= sa;
    wr(32'h48, 16'h0100);
    wr(32'h4c, 16'h0200);
    wr(32'h54, 16'h0001);
    wr(32'h50, pa);
    wr(32'h44, {9'h000, RQ_ADC1});
    wr(32'h108, 16'h0004);
    wr(32'h40, 16'h9022);
    for (int i = 0; i < 4; i++) begin
      exp_q.push_back(pk(2, 2'b11, 10'(((i < 2 ? 11'h100 : 11'h200) | sa) >> 1),
        {6'h15, pa[9:0]}));
      pulse(RQ_ADC1);
      ck_irq(i[0] == 1'b0);
      wr(32'h104, 16'h0004);
    end
    wr(32'h40, 16'h0000);
    $display("alternating indirect test done");
    // Byte inbound, post-increment, alternating one-shot: one move per buffer.
    wr(32'h68, 16'h0301);
    wr(32'h6c, 16'h0310);
    wr(32'h70, pa);
    wr(32'h64, {9'h000, RQ_UART1_TX});
    wr(32'h60, 16'hc003);
    exp_q.push_back(pk(2, 2'b10, 10'h180, {2{pa[7:0]}}));
    pulse(RQ_UART1_TX);
    exp_q.push_back(pk(2, 2'b01, 10'h188, {2{pa[7:0]}}));
    pulse(RQ_UART1_TX);
    pulse(RQ_UART1_TX);
    rd(32'h60, 16'h4003);
    rd(32'h10c, 16'h0300);
    $display("alternating one-shot byte test done");
    for (int c = 0; c < 8; c++) begin
      v = 16'($urandom) & 16'h7fff;
      wr(c * 32 + 4, v);
      rd(c * 32 + 4, v & 16'h007f);
    end
    rd(32'h1f0, 16'h0000);
    rd(32'h100, 16'h000a);
    repeat (4) @(posedge sys_clk);
    `CHK(exp_q.size(), 0)
    $display("register test done");
    print_verdict();
  end
endmodule
